// >>> rtl/scp_gen.sv
// Symmetric S-curve speed profile generator with drive pulse output.
// Assumes a classic Wishbone master, one clock and synchronous inputs.
// Functional notes
// - Mode value 0004h selects symmetric auto S-curve
// - Deceleration reuses acceleration and jerk values
// - Acceleration rises linearly at jerk on start
// - Acceleration falls once gap below rising gain
// - Hold speed at target or zero acceleration
// - Fixed drive decelerates when remaining below accel pulses
// - Deceleration rises then falls, mirror S-curve
// - Accepted speed change uses normal S-curve sequence
// - Speed change ignored while ramping
// - Increase, decrease, sync changes ignored while ramping
// - No target change during fixed-pulse driving
// - One-twelfth rule ends rising acceleration early
// - Surplus pulses emitted around the speed peak
// - Decelerating stop waits for acceleration to zero
// - Remaining pulses run at initial speed as creep
// - Pulse count ignored in continuous driving
// - Triangle prevention on from reset, mode bit disables
`timescale 1ns/1ps
module scp_gen
	import scp_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
)(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Synchronous-action speed change request
	input  wire logic        sync_speed_chg,
	// Drive outputs
	output logic             drive_pulse,
	output logic             busy,
	output logic             constant_speed_flag
);

	// Software-visible registers
	logic [15:0]      profile_mode_register;
	logic [31:0]      jerk_value;
	logic [31:0]      accel_limit;
	logic [31:0]      start_speed;
	logic [31:0]      target_speed;
	logic [31:0]      pulse_count_target;
	logic [31:0]      speed_step;

	// Profile state
	scp_state_t       st_r;
	logic [ACC_W-1:0] accel_r;
	logic [SSC_W-1:0] speed_sc_r;
	logic [SPD_W-1:0] tgt_r;
	logic [SPD_W-1:0] base_r;
	logic [SPD_W-1:0] floor_r;
	logic [SPD_W-1:0] top_r;
	logic             fixed_r;
	logic             stop_pend_r;
	logic             first_acc_r;
	logic [31:0]      total_r;

	// Counters and timing
	logic [31:0]      emitted_r;
	logic [31:0]      acc_pulses_r;
	logic [31:0]      up_pulses_r;
	logic [15:0]      tick_cnt_r;
	logic             tick_r;
	logic [SPD_W:0]   phase_r;

	// Bus decode
	logic             bus_req;
	logic             wr_en;
	logic [31:0]      cmd_w;
	logic [31:0]      rd_dat;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_en   = bus_req & wb_we_i;
	assign cmd_w   = (wr_en && wb_adr_i == OFS_CMD && wb_sel_i[0]) ? wb_dat_i : 32'h0000_0000;

	// Derived values
	logic [SPD_W-1:0] speed_now;
	logic [31:0]      remain;
	logic             sym_mode;
	logic             tri_en;
	logic             tri12_hit;
	logic [35:0]      up_x12;
	logic [ACC_W-1:0] jerk_sc;
	logic [ACC_W-1:0] lim_sc;
	logic [SSC_W-1:0] tgt_sc;
	logic [SSC_W-1:0] floor_sc;
	logic [ACC_W-1:0] accel_inc;
	logic [SSC_W-1:0] speed_add;
	logic [SSC_W-1:0] speed_sub;
	logic             speed_sub_low;

	assign speed_now = speed_sc_r[2*FRAC_BITS +: SPD_W];
	assign remain    = total_r - emitted_r;
	assign sym_mode  = (profile_mode_register & MODE_SEL_MASK) == MODE_SYM_SCURVE;
	assign tri_en    = ~profile_mode_register[MODE_NOTRI_BIT];
	assign up_x12    = {up_pulses_r, 3'b000} + {1'b0, up_pulses_r, 2'b00};
	assign tri12_hit = tri_en & fixed_r & (up_x12 > {4'h0, total_r});
	assign jerk_sc   = {{(ACC_W-32){1'b0}}, jerk_value};
	assign lim_sc    = {{(ACC_W-32-FRAC_BITS){1'b0}}, accel_limit, {FRAC_BITS{1'b0}}};
	assign tgt_sc    = {1'b0, tgt_r, {(2*FRAC_BITS){1'b0}}};
	assign floor_sc  = {1'b0, floor_r, {(2*FRAC_BITS){1'b0}}};
	// Jerk raises the acceleration, clamped at the programmed limit
	assign accel_inc = (accel_r + jerk_sc > lim_sc) ? lim_sc : accel_r + jerk_sc;
	assign speed_add = speed_sc_r + {{(SSC_W-ACC_W){1'b0}}, accel_r};
	assign speed_sub = speed_sc_r - {{(SSC_W-ACC_W){1'b0}}, accel_r};
	assign speed_sub_low = ({{(SSC_W-ACC_W){1'b0}}, accel_r} >= speed_sc_r) ||
		(speed_sub <= floor_sc);

	// Speed change requests: register write, step commands, synchronous action
	logic             chg_req;
	logic [SPD_W-1:0] chg_val;
	logic             chg_ok;

	always_comb
	begin
		chg_req = 1'b0;
		chg_val = tgt_r;
		if (wr_en && wb_adr_i == OFS_TSPD) begin
			chg_req = 1'b1;
			chg_val = wb_dat_i;
		end else if (cmd_w[CMD_SPD_INC]) begin
			chg_req = 1'b1;
			chg_val = tgt_r + speed_step;
		end else if (cmd_w[CMD_SPD_DEC]) begin
			chg_req = 1'b1;
			chg_val = (tgt_r > start_speed + speed_step) ? tgt_r - speed_step : start_speed;
		end else if (sync_speed_chg) begin
			chg_req = 1'b1;
			chg_val = target_speed;
		end
	end

	// Only constant-speed continuous driving takes a new speed
	assign chg_ok = chg_req & (st_r == ST_CONST) & ~fixed_r & ~stop_pend_r;

	// Wishbone ack and read data, one cycle after the request
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req && !wb_we_i) ? rd_dat : 32'h0000_0000;
		end
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb
	begin
		unique case (wb_adr_i)
			OFS_MODE:   rd_dat = {16'h0000, profile_mode_register};
			OFS_JERK:   rd_dat = jerk_value;
			OFS_ALIM:   rd_dat = accel_limit;
			OFS_SSPD:   rd_dat = start_speed;
			OFS_TSPD:   rd_dat = target_speed;
			OFS_PCNT:   rd_dat = pulse_count_target;
			OFS_STEP:   rd_dat = speed_step;
			OFS_STAT:   rd_dat = {25'h0, st_r, 1'b0, fixed_r, constant_speed_flag, busy};
			OFS_SPEED:  rd_dat = speed_now;
			OFS_REMAIN: rd_dat = (fixed_r && st_r != ST_IDLE) ? remain : 32'h0000_0000;
			default:    rd_dat = 32'h0000_0000;
		endcase
	end

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) res[8*i +: 8] = new_v[8*i +: 8];
		end
		return res;
	endfunction

	// Mode register write value after the byte-lane merge; only the low half is kept
	logic [31:0]      mode_wr;

	assign mode_wr = merge({16'h0000, profile_mode_register}, wb_dat_i, wb_sel_i);

	// Parameter registers
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst) begin
			profile_mode_register <= MODE_RST;
			jerk_value            <= PARAM_RST;
			accel_limit           <= PARAM_RST;
			start_speed           <= PARAM_RST;
			target_speed          <= PARAM_RST;
			pulse_count_target    <= PARAM_RST;
			speed_step            <= PARAM_RST;
		end else if (wr_en) begin
			unique case (wb_adr_i)
				OFS_MODE: profile_mode_register <= mode_wr[15:0];
				OFS_JERK: jerk_value         <= merge(jerk_value, wb_dat_i, wb_sel_i);
				OFS_ALIM: accel_limit        <= merge(accel_limit, wb_dat_i, wb_sel_i);
				OFS_SSPD: start_speed        <= merge(start_speed, wb_dat_i, wb_sel_i);
				OFS_TSPD: target_speed       <= merge(target_speed, wb_dat_i, wb_sel_i);
				OFS_PCNT: pulse_count_target <= merge(pulse_count_target, wb_dat_i, wb_sel_i);
				OFS_STEP: speed_step         <= merge(speed_step, wb_dat_i, wb_sel_i);
				default: ;
			endcase
		end
	end

	// Profile update tick divider
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst) begin
			tick_cnt_r <= 16'h0000;
			tick_r     <= 1'b0;
		end else if (st_r == ST_IDLE || tick_cnt_r == 16'(TICK_CYCLES - 1)) begin
			tick_cnt_r <= 16'h0000;
			tick_r     <= (st_r != ST_IDLE);
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
			tick_r     <= 1'b0;
		end
	end

	// Drive pulse generation from the present speed
	logic [SPD_W:0] phase_n;
	logic           may_pulse;

	assign phase_n   = phase_r + {1'b0, speed_now};
	assign may_pulse = ~fixed_r || remain > 32'h1 || (remain == 32'h1 && !drive_pulse);

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst) begin
			phase_r     <= '0;
			drive_pulse <= 1'b0;
		end else if (st_r == ST_IDLE) begin
			phase_r     <= '0;
			drive_pulse <= 1'b0;
		end else if (phase_n >= (SPD_W+1)'(CLK_HZ) && may_pulse) begin
			phase_r     <= phase_n - (SPD_W+1)'(CLK_HZ);
			drive_pulse <= 1'b1;
		end else begin
			phase_r     <= (phase_n >= (SPD_W+1)'(CLK_HZ)) ? phase_r : phase_n;
			drive_pulse <= 1'b0;
		end
	end

	// Pulse counters: emitted, whole acceleration, rising acceleration
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst) begin
			emitted_r    <= 32'h0000_0000;
			acc_pulses_r <= 32'h0000_0000;
			up_pulses_r  <= 32'h0000_0000;
		end else if (st_r == ST_IDLE) begin
			emitted_r    <= 32'h0000_0000;
			acc_pulses_r <= 32'h0000_0000;
			up_pulses_r  <= 32'h0000_0000;
		end else if (drive_pulse) begin
			emitted_r <= emitted_r + 32'h1;
			if (first_acc_r && (st_r == ST_ACC_UP || st_r == ST_ACC_DN))
				acc_pulses_r <= acc_pulses_r + 32'h1;
			if (first_acc_r && st_r == ST_ACC_UP)
				up_pulses_r <= up_pulses_r + 32'h1;
		end
	end

	// Status outputs
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst) begin
			busy                <= 1'b0;
			constant_speed_flag <= 1'b0;
		end else begin
			busy                <= (st_r != ST_IDLE);
			constant_speed_flag <= (st_r == ST_CONST);
		end
	end

	// Profile sequencer and speed/acceleration accumulators
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst) begin
			st_r        <= ST_IDLE;
			accel_r     <= '0;
			speed_sc_r  <= '0;
			tgt_r       <= '0;
			base_r      <= '0;
			floor_r     <= '0;
			top_r       <= '0;
			fixed_r     <= 1'b0;
			stop_pend_r <= 1'b0;
			first_acc_r <= 1'b0;
			total_r     <= 32'h0000_0000;
		end else if (st_r == ST_IDLE) begin
			if (sym_mode && (cmd_w[CMD_START_FIX] || cmd_w[CMD_START_CON])) begin
				fixed_r     <= cmd_w[CMD_START_FIX];
				total_r     <= cmd_w[CMD_START_FIX] ? pulse_count_target : 32'h0;
				tgt_r       <= target_speed;
				base_r      <= start_speed;
				floor_r     <= start_speed;
				speed_sc_r  <= {1'b0, start_speed, {(2*FRAC_BITS){1'b0}}};
				accel_r     <= '0;
				stop_pend_r <= 1'b0;
				first_acc_r <= 1'b1;
				st_r        <= ST_ACC_UP;
			end
		end else if (fixed_r && remain == 32'h0) begin
			st_r       <= ST_IDLE;
			accel_r    <= '0;
			speed_sc_r <= '0;
		end else begin
			if (cmd_w[CMD_DEC_STOP])
				stop_pend_r <= 1'b1;
			unique case (st_r)
				ST_ACC_UP: if (tick_r) begin
					if (speed_add >= tgt_sc) begin
						speed_sc_r  <= tgt_sc;
						accel_r     <= '0;
						first_acc_r <= 1'b0;
						st_r        <= stop_pend_r ? ST_DEC_UP : ST_CONST;
						top_r       <= tgt_r;
					end else begin
						speed_sc_r <= speed_add;
						accel_r    <= accel_inc;
						// Gap below rising gain, twelfth reached, or stop pending
						if (tgt_r - speed_now <= speed_now - base_r || tri12_hit ||
							stop_pend_r || cmd_w[CMD_DEC_STOP])
							st_r <= ST_ACC_DN;
					end
				end
				ST_ACC_DN: if (tick_r) begin
					if (accel_r <= jerk_sc || speed_add >= tgt_sc) begin
						speed_sc_r  <= (speed_add >= tgt_sc) ? tgt_sc : speed_add;
						accel_r     <= '0;
						first_acc_r <= 1'b0;
						top_r       <= (speed_add >= tgt_sc) ? tgt_r :
							speed_add[2*FRAC_BITS +: SPD_W];
						// Deceleration starts only once acceleration is zero
						st_r        <= stop_pend_r ? ST_DEC_UP : ST_CONST;
					end else begin
						speed_sc_r <= speed_add;
						accel_r    <= accel_r - jerk_sc;
					end
				end
				ST_CONST: begin
					// Constant speed; surplus pulses land here at the peak
					if (stop_pend_r || cmd_w[CMD_DEC_STOP]) begin
						floor_r <= start_speed;
						top_r   <= speed_now;
						st_r    <= ST_DEC_UP;
					end else if (fixed_r && remain < acc_pulses_r) begin
						floor_r <= start_speed;
						top_r   <= speed_now;
						st_r    <= ST_DEC_UP;
					end else if (chg_ok && chg_val > speed_now) begin
						tgt_r  <= chg_val;
						base_r <= speed_now;
						st_r   <= ST_ACC_UP;
					end else if (chg_ok && chg_val < speed_now) begin
						tgt_r   <= chg_val;
						floor_r <= (chg_val > start_speed) ? chg_val : start_speed;
						top_r   <= speed_now;
						st_r    <= ST_DEC_UP;
					end
				end
				ST_DEC_UP, ST_DEC_DN: if (tick_r) begin
					if (speed_sub_low || (st_r == ST_DEC_DN && accel_r <= jerk_sc)) begin
						speed_sc_r <= speed_sub_low ? floor_sc : speed_sub;
						accel_r    <= '0;
						if (stop_pend_r && floor_r == start_speed) begin
							st_r       <= ST_IDLE;
							speed_sc_r <= '0;
						end else if (stop_pend_r) begin
							top_r   <= floor_r;
							floor_r <= start_speed;
							st_r    <= ST_DEC_UP;
						end else if (fixed_r)
							st_r <= ST_CREEP;
						else
							st_r <= ST_CONST;
					end else if (st_r == ST_DEC_UP) begin
						speed_sc_r <= speed_sub;
						accel_r    <= accel_inc;
						// Mirror point: remaining drop equals drop gained so far
						if (speed_now - floor_r <= top_r - speed_now)
							st_r <= ST_DEC_DN;
					end else begin
						speed_sc_r <= speed_sub;
						accel_r    <= accel_r - jerk_sc;
					end
				end
				ST_CREEP: begin
					// Remaining pulses at the initial speed until count is met
					if (stop_pend_r || cmd_w[CMD_DEC_STOP]) begin
						st_r       <= ST_IDLE;
						speed_sc_r <= '0;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

endmodule // scp_gen

// >>> rtl/scp_pkg.sv
// Constants for the symmetric S-curve profile generator.
// Assumes a single 10 MHz system clock and a 32-bit classic Wishbone slave port.
package scp_pkg;

	// Clock and profile update timing
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned TICK_HZ       = 1024;
	localparam int unsigned TICK_CYC      = CLK_HZ / TICK_HZ;
	localparam int unsigned FRAC_BITS     = 10;

	// Datapath widths
	localparam int unsigned SPD_W = 32;
	localparam int unsigned ACC_W = SPD_W + FRAC_BITS + 2;
	localparam int unsigned SSC_W = SPD_W + 2 * FRAC_BITS + 1;

	// Register byte offsets
	localparam logic [7:0] OFS_MODE   = 8'h00;
	localparam logic [7:0] OFS_JERK   = 8'h04;
	localparam logic [7:0] OFS_ALIM   = 8'h08;
	localparam logic [7:0] OFS_SSPD   = 8'h0c;
	localparam logic [7:0] OFS_TSPD   = 8'h10;
	localparam logic [7:0] OFS_PCNT   = 8'h14;
	localparam logic [7:0] OFS_CMD    = 8'h18;
	localparam logic [7:0] OFS_STEP   = 8'h1c;
	localparam logic [7:0] OFS_STAT   = 8'h20;
	localparam logic [7:0] OFS_SPEED  = 8'h24;
	localparam logic [7:0] OFS_REMAIN = 8'h28;

	// Profile mode register fields and the one value that selects this profile
	localparam int unsigned MODE_MANUAL_BIT = 0;
	localparam int unsigned MODE_ASYM_BIT   = 1;
	localparam int unsigned MODE_SCURVE_BIT = 2;
	localparam int unsigned MODE_NOTRI_BIT  = 13;
	localparam logic [15:0] MODE_SYM_SCURVE = 16'h0004;
	localparam logic [15:0] MODE_SEL_MASK   = 16'h0007;
	localparam logic [15:0] MODE_RST        = 16'h0000;

	// Command register bits
	localparam int unsigned CMD_START_FIX = 0;
	localparam int unsigned CMD_START_CON = 1;
	localparam int unsigned CMD_DEC_STOP  = 2;
	localparam int unsigned CMD_SPD_INC   = 3;
	localparam int unsigned CMD_SPD_DEC   = 4;

	// Reset values of parameter registers
	localparam logic [31:0] PARAM_RST = 32'h0000_0000;

	// Profile phases
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ACC_UP = 3'b001,
		ST_ACC_DN = 3'b010,
		ST_CONST  = 3'b011,
		ST_DEC_UP = 3'b100,
		ST_DEC_DN = 3'b101,
		ST_CREEP  = 3'b110
	} scp_state_t;

endpackage

// >>> verif/scp_gen_assertions.sv
// Port checker for the S-curve profile generator.
// Bound to every scp_gen instance; it sees only the generator's ports.
`timescale 1ns/1ps
module scp_gen_checker
	import scp_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
)(
	// Clock and reset
	input wire logic        clock,
	input wire logic        sys_rst,
	// Register bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	// Drive side
	input wire logic        sync_speed_chg,
	input wire logic        drive_pulse,
	input wire logic        busy,
	input wire logic        constant_speed_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Command register write in progress
	wire logic cmd_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == OFS_CMD;

	// Bus request not yet answered, then its answer
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	property p_ack_next;
		s_req |=> s_ans;
	endproperty
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	property p_quiet;
		$fell(sys_rst) |-> !busy && !drive_pulse && !constant_speed_flag && !wb_ack_o;
	endproperty
	property p_busy_start;
		$rose(busy) |-> $past(cmd_w) || $past(cmd_w, 2);
	endproperty
	property p_pulse_gap;
		drive_pulse |=> !drive_pulse;
	endproperty
	property p_pulse_busy;
		drive_pulse |-> busy || $past(busy);
	endproperty
	property p_const_busy;
		constant_speed_flag |-> busy;
	endproperty

	a_ack_next:   assert property (p_ack_next) else $error("bus answer missing or too long");
	a_ack_cause:  assert property (p_ack_cause) else $error("ack without request");
	a_dat_idle:   assert property (p_dat_idle) else $error("read data not zero outside ack");
	a_quiet:      assert property (p_quiet) else $error("output active after reset");
	a_busy_start: assert property (p_busy_start) else $error("busy rose without start");
	a_pulse_gap:  assert property (p_pulse_gap) else $error("drive pulse too wide");
	a_pulse_busy: assert property (p_pulse_busy) else $error("pulse while idle");
	a_const_busy: assert property (p_const_busy) else $error("cruise flag while idle");
endmodule // scp_gen_checker

bind scp_gen scp_gen_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock(clock), .sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sync_speed_chg(sync_speed_chg), .drive_pulse(drive_pulse), .busy(busy),
	.constant_speed_flag(constant_speed_flag));

// >>> verif/scp_motor_model.sv
// Pulse counter standing in for the motor driver.
// Counts drive steps and keeps the shortest step spacing since the last clear.
`timescale 1ns/1ps
module scp_motor_model (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Step input and counter clear
	input  wire logic        drive_pulse,
	input  wire logic        clr,
	// Counts
	output logic      [31:0] pulse_cnt_r,
	output logic      [31:0] min_gap_r
);
	logic [31:0] gap_r;

	// Count steps and track the tightest spacing
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pulse_cnt_r <= 32'h0;
			min_gap_r   <= 32'hffff_ffff;
			gap_r       <= 32'h0;
		end
		else if (clr)
		begin
			pulse_cnt_r <= 32'h0;
			min_gap_r   <= 32'hffff_ffff;
			gap_r       <= 32'h0;
		end
		else if (drive_pulse)
		begin
			pulse_cnt_r <= pulse_cnt_r + 32'h1;
			if (gap_r < min_gap_r)
				min_gap_r <= gap_r;
			gap_r <= 32'h1;
		end
		else
			gap_r <= gap_r + 32'h1;
	end
endmodule // scp_motor_model

// >>> verif/scp_gen_tb.sv
// Testbench for the S-curve profile generator: bus tasks and move scenarios.
// Assumes the package, the generator and the pulse counter model are compiled first.
`timescale 1ns/1ps
module scp_gen_tb;
	import scp_pkg::*;
	localparam logic [31:0] SV = 32'h0001_86a0;
	localparam logic [31:0] DV = 32'h0007_a120;
	localparam logic [31:0] NV = 32'h0004_93e0;
	logic        clock, sys_rst, cyc, stb, we, sync, clr, ack, pul, bsy, cst;
	logic [7:0]  adr;
	logic [31:0] dat, rdat, q, s1, s2, s3, cnt, gap;
	int          error_cnt, samples_checked;

	// Design and motor-side counter
	scp_gen #(.TICK_CYCLES(10)) u_dut (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sync_speed_chg(sync), .drive_pulse(pul),
		.busy(bsy), .constant_speed_flag(cst));
	scp_motor_model u_motor (.clock(clock), .sys_rst(sys_rst), .drive_pulse(pul), .clr(clr),
		.pulse_cnt_r(cnt), .min_gap_r(gap));

	// 10 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic wrap_up;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask

	// One classic Wishbone cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		do
		begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 20)
		begin
			error_cnt++;
			$display("[ERR] %0t bus timeout", $time);
			wrap_up();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask

	// Wait for busy (sel 0) or cruise flag (sel 1) to reach a level
	task automatic wait_for(input int sel, input logic v, input int lim);
		int n;
		n = 0;
		while ((sel ? cst : bsy) !== v && n < lim)
		begin
			@(posedge clock);
			n++;
		end
		if (n >= lim)
		begin
			error_cnt++;
			$display("[ERR] %0t wait timeout", $time);
			wrap_up();
		end
	endtask

	// Clear the counter, then issue a start command
	task automatic move(input logic [31:0] c);
		@(posedge clock);
		clr <= 1'b1;
		@(posedge clock);
		clr <= 1'b0;
		wr(OFS_CMD, c);
		// Busy lags the start by one cycle; see it rise before waiting for the end
		wait_for(0, 1'b1, 10);
	endtask

	task automatic sync_pulse;
		@(posedge clock);
		sync <= 1'b1;
		@(posedge clock);
		sync <= 1'b0;
	endtask

	// Main sequence
	initial
	begin
		{cyc, stb, we, sync, clr} = '0;
		adr = '0;
		dat = '0;
		sys_rst = 1'b1;
		error_cnt = 0;
		samples_checked = 0;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		// Reset values, unmapped slot, mode readback
		for (int a = 0; a <= 'h28; a += 4)
			rd(8'(a), 32'h0);
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0);
		wr(OFS_MODE, 32'h1234_2004);
		rd(OFS_MODE, 32'h0000_2004);
		// Any other selection refuses to start
		for (int m = 0; m < 8; m++)
		begin
			if (m == 4)
				continue;
			wr(OFS_MODE, 32'(m));
			wr(OFS_CMD, 32'h1);
			rd(OFS_STAT, 32'h0);
		end
		wr(OFS_MODE, {16'h0, MODE_SYM_SCURVE});
		wr(OFS_JERK, 32'h0061_a800);
		wr(OFS_ALIM, 32'h1fff_ffff);
		wr(OFS_SSPD, SV);
		wr(OFS_TSPD, DV);
		wr(OFS_PCNT, 32'h3e8);
		rd(OFS_JERK, 32'h0061_a800);
		// Fixed move long enough to cruise
		move(32'h1);
		repeat (200) @(posedge clock);
		bus(1'b0, OFS_SPEED, 32'h0);
		s1 = q;
		repeat (400) @(posedge clock);
		bus(1'b0, OFS_SPEED, 32'h0);
		s2 = q;
		repeat (400) @(posedge clock);
		bus(1'b0, OFS_SPEED, 32'h0);
		s3 = q;
		chk(32'((s3 - s2) > (s2 - s1) && s2 > s1), 32'h1);
		wait_for(1, 1'b1, 20000);
		rd(OFS_SPEED, DV);
		wr(OFS_TSPD, NV);
		sync_pulse();
		repeat (20) @(posedge clock);
		chk(32'(cst), 32'h1);
		rd(OFS_SPEED, DV);
		wait_for(0, 1'b0, 40000);
		chk(cnt, 32'h3e8);
		chk(32'(gap >= 32'h14), 32'h1);
		rd(OFS_REMAIN, 32'h0);
		// Short fixed move never reaches the drive speed
		wr(OFS_PCNT, 32'h3c);
		move(32'h1);
		wait_for(0, 1'b0, 40000);
		chk(cnt, 32'h3c);
		chk(32'(gap > 32'h32), 32'h1);
		// Continuous move: ramp ignores changes, cruise accepts them
		wr(OFS_TSPD, DV);
		move(32'h2);
		repeat (1000) @(posedge clock);
		wr(OFS_STEP, 32'h0001_86a0);
		wr(OFS_TSPD, NV);
		wr(OFS_CMD, 32'h8);
		wr(OFS_CMD, 32'h10);
		sync_pulse();
		wait_for(1, 1'b1, 20000);
		rd(OFS_SPEED, DV);
		wr(OFS_TSPD, NV);
		wait_for(1, 1'b0, 10);
		wait_for(1, 1'b1, 20000);
		rd(OFS_SPEED, NV);
		// Step increase at cruise ramps up to the new target
		wr(OFS_CMD, 32'h8);
		wait_for(1, 1'b0, 10);
		wait_for(1, 1'b1, 20000);
		rd(OFS_SPEED, 32'h0006_1a80);
		chk(32'(cnt > 32'h3c), 32'h1);
		wr(OFS_CMD, 32'h4);
		wait_for(0, 1'b0, 40000);
		// Decelerating stop in mid acceleration
		wr(OFS_TSPD, DV);
		move(32'h2);
		repeat (1500) @(posedge clock);
		wr(OFS_CMD, 32'h4);
		bus(1'b0, OFS_SPEED, 32'h0);
		s1 = q;
		repeat (300) @(posedge clock);
		bus(1'b0, OFS_SPEED, 32'h0);
		chk(32'(q > s1), 32'h1);
		wait_for(0, 1'b0, 40000);
		wrap_up();
	end
endmodule // scp_gen_tb
